// *** src/fcahost_regs.vh ***
// Pin timing, command codes and sequence constants for the flash command host.
`ifndef FCAHOST_REGS_VH
`define FCAHOST_REGS_VH

`define FCA_CLK_MHZ       100
`define FCA_T_WP_NS       35
`define FCA_T_WPH_NS      30
`define FCA_T_ACC_NS      70
`define FCA_T_RP_NS       500
`define FCA_T_RH_NS       50
`define FCA_WP_CYC        ((`FCA_T_WP_NS * `FCA_CLK_MHZ + 999) / 1000)
`define FCA_WPH_CYC       ((`FCA_T_WPH_NS * `FCA_CLK_MHZ + 999) / 1000)
`define FCA_ACC_CYC       ((`FCA_T_ACC_NS * `FCA_CLK_MHZ + 999) / 1000)
`define FCA_RP_CYC        ((`FCA_T_RP_NS * `FCA_CLK_MHZ + 999) / 1000)
`define FCA_RH_CYC        ((`FCA_T_RH_NS * `FCA_CLK_MHZ + 999) / 1000)
`define FCA_SYNC_CYC      4

`define FCA_OP_READ       4'h0
`define FCA_OP_RESET      4'h1
`define FCA_OP_IDREAD     4'h2
`define FCA_OP_PROTVER    4'h3
`define FCA_OP_PROGRAM    4'h4
`define FCA_OP_CHIPERASE  4'h5
`define FCA_OP_SECTERASE  4'h6
`define FCA_OP_SUSPEND    4'h7
`define FCA_OP_RESUME     4'h8
`define FCA_OP_HVIDREAD   4'h9
`define FCA_OP_HWRESET    4'ha

`define FCA_ADDR_UNLOCK1  18'h00555
`define FCA_ADDR_UNLOCK2  18'h002aa
`define FCA_DATA_UNLOCK1  8'haa
`define FCA_DATA_UNLOCK2  8'h55
`define FCA_DATA_RESET    8'hf0
`define FCA_DATA_IDENT    8'h90
`define FCA_DATA_PROGRAM  8'ha0
`define FCA_DATA_ERASE    8'h80
`define FCA_DATA_CHIP     8'h10
`define FCA_DATA_SECTOR   8'h30
`define FCA_DATA_SUSPEND  8'hb0
`define FCA_DATA_RESUME   8'h30
`define FCA_PROT_LOW      13'h0002
`define FCA_SECT_MSB      17
`define FCA_SECT_LSB      13
`define FCA_HV_QUAL_BIT   6

`endif

// *** src/fcahost_pin_sync.v ***
// Three-stage synchroniser for the data pins with an agreement flag.
`timescale 1ns/1ps
`default_nettype none
module fcahost_pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clock,    // System clock.
    input  wire             rst_q,    // Synchronised reset, active low.
    input  wire [WIDTH-1:0] pin_in,   // Raw pin levels.
    output wire [WIDTH-1:0] pin_sync, // Third-stage value.
    output wire             stable    // Second and third stages agree on every bit.
);
    wire [WIDTH-1:0] agree;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1;
            reg s2;
            reg s3;
            always @(posedge clock or negedge rst_q) begin
                if (!rst_q) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign pin_sync[i] = s3;
            assign agree[i]    = (s2 == s3);
        end
    endgenerate

    assign stable = &agree;
endmodule
`default_nettype wire

// *** src/fcahost.v ***
// Host that drives a byte-wide flash through its command sequences and pins.
//
// How it works
// - High-voltage read: qualifier low, low bits select.
// - Unlock pair, 90H, then read low-bit location.
// - Protect verify reads sector address with x02H.
// - Unlock writes AAH at 555H, 55H at 2AAH.
// - Program is unlock, A0H, then target byte.
// - Erase is six writes, 10H chip, 30H sector.
// - Reads drop select and gate; writes select and strobe.
`timescale 1ns/1ps
`default_nettype none
`include "fcahost_regs.vh"
module fcahost #(
    parameter AW = 18,
    parameter RP_CYC = `FCA_RP_CYC
) (
    input  wire          clock,        // System clock, 100 MHz.
    input  wire          rst_n,        // Asynchronous reset, active low.
    input  wire          cmd_valid,    // Request strobe.
    input  wire [3:0]    cmd_op,       // Operation code.
    input  wire [AW-1:0] cmd_addr,     // Target address or sector.
    input  wire [7:0]    cmd_data,     // Byte to program.
    output reg           cmd_ready,    // Ready for a request.
    output reg           rsp_valid,    // One-cycle completion pulse.
    output reg  [7:0]    rsp_data,     // Byte read, zero for write ops.
    output reg  [AW-1:0] flash_addr,   // Address pins.
    input  wire [7:0]    flash_dq_in,  // Data pin levels.
    output reg  [7:0]    flash_dq_out, // Data driven on the pins.
    output reg           flash_dq_oe,  // High while the host drives the data pins.
    output reg           flash_ce_n,   // Chip select, active low.
    output reg           flash_oe_n,   // Output gate, active low.
    output reg           flash_we_n,   // Write strobe, active low.
    output reg           flash_reset_n,// Hardware reset, active low.
    output reg           id_high_voltage // Raises the identification address pin.
);
    localparam S_IDLE  = 3'd0;
    localparam S_SETUP = 3'd1;
    localparam S_STRB  = 3'd2;
    localparam S_HOLD  = 3'd3;
    localparam S_READ  = 3'd4;
    localparam S_GAP   = 3'd5;
    localparam S_HWRST = 3'd6;
    localparam S_DONE  = 3'd7;

    reg          rst_m;
    reg          rst_q;
    reg [2:0]    state;
    reg [2:0]    step;
    reg [15:0]   cnt;
    reg [3:0]    op;
    reg [AW-1:0] uaddr;
    reg [7:0]    udata;
    wire [7:0]   dq_sync;
    wire         dq_stable;
    wire [27:0]  cur;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_q <= rst_m;
        end
    end

    fcahost_pin_sync #(.WIDTH(8)) u_sync (
        .clock    (clock),
        .rst_q    (rst_q),
        .pin_in   (flash_dq_in),
        .pin_sync (dq_sync),
        .stable   (dq_stable)
    );

    // Returns {last, is_read, address, data} for one step of an operation.
    function [27:0] seq;
        input [3:0]  o;
        input [2:0]  s;
        input [17:0] a;
        input [7:0]  d;
        reg   [17:0] sect;
        begin
            sect = {a[`FCA_SECT_MSB:`FCA_SECT_LSB], 13'h0000};
            seq  = {2'b10, a, `FCA_DATA_RESET};
            case (s)
                3'd0: seq = {2'b00, `FCA_ADDR_UNLOCK1, `FCA_DATA_UNLOCK1};
                3'd1: seq = {2'b00, `FCA_ADDR_UNLOCK2, `FCA_DATA_UNLOCK2};
                3'd3: seq = {2'b00, `FCA_ADDR_UNLOCK1, `FCA_DATA_UNLOCK1};
                3'd4: seq = {2'b00, `FCA_ADDR_UNLOCK2, `FCA_DATA_UNLOCK2};
                default: seq = {2'b10, a, d};
            endcase
            case (o)
                `FCA_OP_READ:    seq = {2'b11, a, 8'h00};
                `FCA_OP_RESET:   seq = {2'b10, a, `FCA_DATA_RESET};
                `FCA_OP_SUSPEND: seq = {2'b10, a, `FCA_DATA_SUSPEND};
                `FCA_OP_RESUME:  seq = {2'b10, a, `FCA_DATA_RESUME};
                `FCA_OP_HVIDREAD: begin
                    seq = {2'b11, 16'h0000, a[1:0], 8'h00};
                    seq[8 + `FCA_HV_QUAL_BIT] = 1'b0;
                end
                `FCA_OP_IDREAD, `FCA_OP_PROTVER: begin
                    if (s == 3'd2)
                        seq = {2'b00, `FCA_ADDR_UNLOCK1, `FCA_DATA_IDENT};
                    else if (s == 3'd3 && o == `FCA_OP_IDREAD)
                        seq = {2'b11, 16'h0000, a[1:0], 8'h00};
                    else if (s == 3'd3)
                        seq = {2'b11, sect | {5'h00, `FCA_PROT_LOW}, 8'h00};
                end
                `FCA_OP_PROGRAM: begin
                    if (s == 3'd2)
                        seq = {2'b00, `FCA_ADDR_UNLOCK1, `FCA_DATA_PROGRAM};
                    else if (s == 3'd3)
                        seq = {2'b10, a, d};
                end
                `FCA_OP_CHIPERASE, `FCA_OP_SECTERASE: begin
                    if (s == 3'd2)
                        seq = {2'b00, `FCA_ADDR_UNLOCK1, `FCA_DATA_ERASE};
                    else if (s == 3'd5 && o == `FCA_OP_CHIPERASE)
                        seq = {2'b10, `FCA_ADDR_UNLOCK1, `FCA_DATA_CHIP};
                    else if (s == 3'd5)
                        seq = {2'b10, sect, `FCA_DATA_SECTOR};
                end
                default: seq = {2'b10, a, `FCA_DATA_RESET};
            endcase
        end
    endfunction

    assign cur = seq(op, step, uaddr, udata);

    always @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            state           <= S_IDLE;
            step            <= 3'd0;
            cnt             <= 16'h0000;
            op              <= 4'h0;
            uaddr           <= {AW{1'b0}};
            udata           <= 8'h00;
            cmd_ready       <= 1'b0;
            rsp_valid       <= 1'b0;
            rsp_data        <= 8'h00;
            flash_addr      <= {AW{1'b0}};
            flash_dq_out    <= 8'h00;
            flash_dq_oe     <= 1'b0;
            flash_ce_n      <= 1'b1;
            flash_oe_n      <= 1'b1;
            flash_we_n      <= 1'b1;
            flash_reset_n   <= 1'b1;
            id_high_voltage <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op        <= cmd_op;
                        uaddr     <= cmd_addr;
                        udata     <= cmd_data;
                        step      <= 3'd0;
                        cnt       <= 16'h0000;
                        rsp_data  <= 8'h00;
                        if (cmd_op == `FCA_OP_HWRESET) begin
                            flash_reset_n <= 1'b0;
                            flash_dq_oe   <= 1'b0;
                            state         <= S_HWRST;
                        end else begin
                            id_high_voltage <= (cmd_op == `FCA_OP_HVIDREAD);
                            state           <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    flash_addr <= cur[25:8];
                    flash_ce_n <= 1'b0;
                    flash_we_n <= 1'b1;
                    cnt        <= 16'h0000;
                    if (cur[26]) begin
                        flash_dq_oe <= 1'b0;
                        flash_oe_n  <= 1'b0;
                        state       <= S_READ;
                    end else begin
                        flash_oe_n   <= 1'b1;
                        flash_dq_out <= cur[7:0];
                        flash_dq_oe  <= 1'b1;
                        state        <= S_STRB;
                    end
                end
                S_STRB: begin
                    flash_we_n <= 1'b0;
                    cnt        <= cnt + 16'h0001;
                    // The strobe goes low on the first count, so it must rise one count
                    // later than the width to stay low for the full write pulse.
                    if (cnt == `FCA_WP_CYC) begin
                        flash_we_n <= 1'b1;
                        cnt        <= 16'h0000;
                        state      <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == (`FCA_WPH_CYC - 1)) begin
                        flash_ce_n  <= 1'b1;
                        flash_dq_oe <= 1'b0;
                        cnt         <= 16'h0000;
                        state       <= cur[27] ? S_DONE : S_SETUP;
                        step        <= step + 3'd1;
                    end
                end
                S_READ: begin
                    if (cnt < (`FCA_ACC_CYC + `FCA_SYNC_CYC))
                        cnt <= cnt + 16'h0001;
                    else if (dq_stable) begin
                        rsp_data   <= dq_sync;
                        flash_oe_n <= 1'b1;
                        flash_ce_n <= 1'b1;
                        cnt        <= 16'h0000;
                        state      <= S_GAP;
                    end
                end
                S_GAP: begin
                    state <= S_DONE;
                end
                S_HWRST: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == RP_CYC - 1)
                        flash_reset_n <= 1'b1;
                    if (cnt == RP_CYC + `FCA_RH_CYC - 1)
                        state <= S_DONE;
                end
                S_DONE: begin
                    id_high_voltage <= 1'b0;
                    rsp_valid       <= 1'b1;
                    state           <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** testbench/fcahost_sva.sv ***
// Assertions on the pins and command sequences of the flash command host.
`timescale 1ns/1ps
`default_nettype none
module fcahost_sva #(
    parameter AW = 18
) (
    input wire logic          clock,          // Clock.
    input wire logic          rst_n,          // Reset.
    input wire logic          cmd_valid,      // Request.
    input wire logic [3:0]    cmd_op,         // Operation.
    input wire logic          cmd_ready,      // Ready.
    input wire logic [AW-1:0] flash_addr,     // Address pins.
    input wire logic [7:0]    flash_dq_out,   // Data driven.
    input wire logic          flash_dq_oe,    // Data enable.
    input wire logic          flash_ce_n,     // Select.
    input wire logic          flash_oe_n,     // Output gate.
    input wire logic          flash_we_n,     // Write strobe.
    input wire logic          flash_reset_n,  // Pin reset.
    input wire logic          id_high_voltage // High voltage.
);
    logic [3:0]  op_q;
    logic [2:0]  wcnt;
    logic        we_q;
    logic [21:0] ex;
    wire         we_fall = we_q && !flash_we_n;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Expected write of each step: {address checked, data checked, address, data}.
    function automatic logic [21:0] fexp(input logic [3:0] o, input logic [2:0] c);
        logic m;
        logic e;
        m = o >= 4'h2 && o <= 4'h6;
        e = o == 4'h5 || o == 4'h6;
        case (c)
            3'h0: fexp = m ? 22'h3555aa : o == 4'h1 || o > 4'ha ? 22'h1000f0 :
                o == 4'h7 ? 22'h1000b0 : o == 4'h8 ? 22'h100030 : 22'h0;
            3'h1: fexp = m ? 22'h32aa55 : 22'h0;
            3'h2: fexp = !m ? 22'h0 : o < 4'h4 ? 22'h355590 : o == 4'h4 ? 22'h3555a0 : 22'h355580;
            3'h3: fexp = e ? 22'h3555aa : 22'h0;
            3'h4: fexp = e ? 22'h32aa55 : 22'h0;
            3'h5: fexp = o == 4'h5 ? 22'h355510 : o == 4'h6 ? 22'h100030 : 22'h0;
            default: fexp = 22'h0;
        endcase
    endfunction
    always @* ex = fexp(op_q, wcnt);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= 4'h0;
            wcnt <= 3'h0;
            we_q <= 1'b1;
        end else begin
            we_q <= flash_we_n;
            if (cmd_valid && cmd_ready) begin
                op_q <= cmd_op;
                wcnt <= 3'h0;
            end else if (we_fall)
                wcnt <= wcnt + 3'h1;
        end
    end
    property p_read_pins; !flash_oe_n |-> !flash_ce_n && flash_we_n; endproperty
    a_read_pins: assert property (p_read_pins) else $error("bad read pins");
    property p_write_pins; !flash_we_n |-> !flash_ce_n && flash_oe_n; endproperty
    a_write_pins: assert property (p_write_pins) else $error("bad write pins");
    property p_dq_release; !flash_oe_n || !flash_reset_n |-> !flash_dq_oe; endproperty
    a_dq_release: assert property (p_dq_release) else $error("data not released");
    property p_hv_qual; id_high_voltage && !flash_oe_n |-> !flash_addr[6]; endproperty
    a_hv_qual: assert property (p_hv_qual) else $error("qualifier high");
    property p_we_width; $fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n; endproperty
    a_we_width: assert property (p_we_width) else $error("bad strobe width");
    property p_seq_addr; we_fall && ex[21] |-> flash_addr == AW'(ex[19:8]); endproperty
    a_seq_addr: assert property (p_seq_addr) else $error("bad command address");
    property p_seq_data; we_fall && ex[20] |-> flash_dq_oe && flash_dq_out == ex[7:0]; endproperty
    a_seq_data: assert property (p_seq_data) else $error("bad command data");
    property p_prot_read; !flash_oe_n && op_q == 4'h3 |-> flash_addr[12:0] == 13'h0002; endproperty
    a_prot_read: assert property (p_prot_read) else $error("bad verify address");
endmodule
`default_nettype wire

// *** testbench/fca_flash_model.sv ***
// Behavioural byte-wide flash seen from its pins.
`timescale 1ns/1ps
`default_nettype none
module fca_flash_model #(
    parameter logic [7:0]  MFR  = 8'h3c,       // Arbitrary maker code.
    parameter logic [7:0]  DEV  = 8'h4d,       // Arbitrary part code.
    parameter logic [31:0] PROT = 32'h00000000 // Protected sectors.
) (
    input  wire logic [17:0] flash_addr,      // Address.
    input  wire logic [7:0]  flash_dq_out,    // Host data.
    input  wire logic        flash_dq_oe,     // Host drives.
    input  wire logic        flash_ce_n,      // Select.
    input  wire logic        flash_oe_n,      // Output gate.
    input  wire logic        flash_we_n,      // Strobe.
    input  wire logic        flash_reset_n,   // Pin reset.
    input  wire logic        id_high_voltage, // High voltage.
    output var  logic [7:0]  flash_dq_in      // Data out.
);
    logic [7:0]  mem [int];
    logic [17:0] wa;
    logic [7:0]  last = 8'h00;
    int          st;
    bit          idm;
    bit          ers;
    wire         drv = flash_reset_n && !flash_ce_n && !flash_oe_n;
    function automatic logic [7:0] idc(input logic [17:0] a);
        return a[1:0] == 2'h0 ? MFR : a[1:0] == 2'h1 ? DEV :
            a[1:0] == 2'h2 ? {7'h0, PROT[a[17:13]]} : 8'h00;
    endfunction
    task automatic wipe(input int s);
        foreach (mem[k])
            if ((s < 0 || k[17:13] == s) && !PROT[k[17:13]])
                mem[k] = 8'hff;
    endtask
    task automatic step(input logic [17:0] a, input logic [7:0] d);
        bit u1;
        bit u2;
        u1 = a[11:0] == 12'h555;
        u2 = a[11:0] == 12'h2aa;
        if ((st == 0 || st == 4) && u1 && d == 8'haa) st++;
        else if ((st == 1 || st == 5) && u2 && d == 8'h55) st++;
        else if (st == 2 && u1 && (d == 8'h90 || d == 8'ha0 || d == 8'h80)) begin
            idm = idm || d == 8'h90;
            st = d == 8'h90 ? 0 : d == 8'ha0 ? 3 : 4;
        end else if (st == 3) begin
            if (!PROT[a[17:13]])
                mem[a] = d;
            st = 0;
        end else if (st == 6 && (u1 && d == 8'h10 || d == 8'h30)) begin
            wipe(d == 8'h10 ? -1 : int'(a[17:13]));
            ers = ers || d == 8'h30;
            st = 0;
        end else if (st == 0 && ers && (d == 8'hb0 || d == 8'h30))
            st = 0;
        else begin
            st = 0;
            idm = 0;
        end
    endtask
    always @(negedge flash_we_n)
        if (!flash_ce_n && flash_reset_n)
            wa = flash_addr;
    always @(posedge flash_we_n)
        if (!flash_ce_n && flash_reset_n && flash_dq_oe)
            step(wa, flash_dq_out);
    always @(negedge flash_reset_n) begin
        st = 0;
        idm = 0;
        ers = 0;
    end
    // A released bus shows the inverse of the last byte, never a stale copy.
    always @(flash_addr, id_high_voltage, idm, drv) begin
        if (drv)
            last = id_high_voltage && !flash_addr[6] || idm ? idc(flash_addr) :
                mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
        flash_dq_in = drv ? last : ~last;
    end
endmodule
`default_nettype wire

// *** testbench/tb_flash_command_autoselect.sv ***
// Self-checking bench for the flash command host.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_autoselect;
    localparam logic [7:0]  MFR  = 8'h3c; // Arbitrary maker code.
    localparam logic [7:0]  DEV  = 8'h4d; // Arbitrary part code.
    localparam logic [31:0] PROT = 32'h00000005;
    logic        clock, rst_n, cmd_valid;
    logic [3:0]  cmd_op;
    logic [17:0] cmd_addr;
    logic [7:0]  cmd_data;
    wire         cmd_ready, rsp_valid, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
    wire         flash_reset_n, id_high_voltage;
    wire  [7:0]  rsp_data, flash_dq_in, flash_dq_out;
    wire  [17:0] flash_addr;
    logic [7:0]  rm [int];
    logic [17:0] pa [2] = '{18'h02001, 18'h00001};
    bit          ridm, rers;
    int          n_fail, n_compared;
    fcahost #(.AW(18), .RP_CYC(4)) dut (
        .clock, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid,
        .rsp_data, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
        .flash_oe_n, .flash_we_n, .flash_reset_n, .id_high_voltage
    );
    fca_flash_model #(.MFR(MFR), .DEV(DEV), .PROT(PROT)) u_flash (
        .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n,
        .flash_reset_n, .id_high_voltage, .flash_dq_in
    );
    always #5 clock = ~clock;
    function automatic logic [7:0] idc(input logic [17:0] a);
        return a[1:0] == 2'h0 ? MFR : a[1:0] == 2'h1 ? DEV :
            a[1:0] == 2'h2 ? {7'h0, PROT[a[17:13]]} : 8'h00;
    endfunction
    task automatic finish_test;
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic do_op(input logic [3:0] op, input logic [17:0] a, input logic [7:0] d);
        int i;
        logic [7:0] e;
        i = 0;
        while (cmd_ready !== 1'b1 && i < 600) begin
            @(negedge clock);
            i++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        e = 8'h00;
        if (op == 4'h5 || op == 4'h6)
            foreach (rm[k])
                if ((op == 4'h5 || k[17:13] == a[17:13]) && !PROT[k[17:13]])
                    rm[k] = 8'hff;
        case (op)
            4'h0: e = ridm ? idc(a) : rm.exists(a) ? rm[a] : 8'hff;
            4'h2, 4'h9: e = idc({16'h0, a[1:0]});
            4'h3: e = idc({a[17:13], 13'h0002});
            4'h4: if (!PROT[a[17:13]]) rm[a] = d;
            4'h5: e = 8'h00;
            4'h6: rers = 1'b1;
            4'h7, 4'h8: ridm = ridm && rers;
            4'ha: {ridm, rers} = 2'b00;
            default: ridm = 1'b0;
        endcase
        ridm = ridm || op == 4'h2 || op == 4'h3;
        while (rsp_valid !== 1'b1 && i < 600) begin
            @(negedge clock);
            i++;
        end
        n_compared++;
        if (rsp_data !== e || i >= 600) begin
            n_fail++;
            $display("mismatch %0t %h %h", $time, rsp_data, e);
        end
        if (i >= 600)
            finish_test();
    endtask
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_addr = 18'h0;
        cmd_data = 8'h00;
        void'($urandom(59777));
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        for (int k = 0; k < 16; k++)
            do_op(4'(k), 18'($urandom) & 18'h0e003, 8'($urandom));
        for (int j = 0; j < 2; j++) begin
            do_op(4'h1, 18'h0, 8'h00);
            do_op(4'h4, pa[j], 8'h3c);
            do_op(4'h0, pa[j], 8'h00);
        end
        do_op(4'h6, 18'h02000, 8'h00);
        do_op(4'h7, 18'h0, 8'h00);
        do_op(4'h8, 18'h0, 8'h00);
        repeat (60)
            do_op(4'($urandom), 18'($urandom) & 18'h0e003, 8'($urandom));
        finish_test();
    end
endmodule
bind fcahost fcahost_sva #(.AW(AW)) u_sva (
    .clock, .rst_n, .cmd_valid, .cmd_op, .cmd_ready, .flash_addr, .flash_dq_out, .flash_dq_oe,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .id_high_voltage
);
`default_nettype wire
